// ==== rtl/rtp_pkg.sv ====
// Shared types and constants of the reload timer channel with pulse measurement.
package rtp_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned PRE_W = 9;

  // Prescaler masks: a tick falls when the masked divider bits are all ones.
  localparam logic [8:0] PRE_MASK_DIV2   = 9'h001;
  localparam logic [8:0] PRE_MASK_DIV16  = 9'h00F;
  localparam logic [8:0] PRE_MASK_DIV64  = 9'h03F;
  localparam logic [8:0] PRE_MASK_DIV512 = 9'h1FF;

  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [7:0]  MODE_RESET   = 8'h00;

  // Count source selector codes.
  localparam logic [1:0] SRC_DIV2   = 2'h0;
  localparam logic [1:0] SRC_DIV16  = 2'h1;
  localparam logic [1:0] SRC_DIV64  = 2'h2;
  localparam logic [1:0] SRC_DIV512 = 2'h3;

  // Edge selector codes, shared by event counting and measurement.
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // Number of measurement edges after start before the capture is valid.
  localparam logic [1:0] EDGES_FOR_VALID = 2'h2;

  typedef enum logic [1:0] {
    OP_TIMER,
    OP_EVENT,
    OP_MEASURE,
    OP_UNUSED
  } rtp_op_e;

  // Mode register, bit 7 down to bit 0.
  typedef struct packed {
    logic [1:0] src_sel;
    logic [1:0] spare;
    logic [1:0] edge_sel;
    rtp_op_e    op;
  } rtp_mode_s;

  // One software access to the channel count register.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } rtp_cnt_acc_s;

endpackage : rtp_pkg

// ==== rtl/rtp_prescaler.sv ====
// Free-running divider that yields the selected prescaled count tick.
`timescale 1ns/1ps
`default_nettype none

module rtp_prescaler
  import rtp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] src_sel,
  output var  logic       tick
);

  logic [PRE_W-1:0] div_q;
  logic [PRE_W-1:0] mask;
  logic             tick_q;

  always_comb begin
    case (src_sel)
      SRC_DIV2:   mask = PRE_MASK_DIV2;
      SRC_DIV16:  mask = PRE_MASK_DIV16;
      SRC_DIV64:  mask = PRE_MASK_DIV64;
      default:    mask = PRE_MASK_DIV512;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 9'h001;
    end
  end

  // The tick is one clock wide, once per selected division period.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= ((div_q & mask) == mask);
    end
  end

  assign tick = tick_q;

endmodule : rtp_prescaler

`default_nettype wire

// ==== rtl/rtp_channel.sv ====
// One 16-bit reload timer channel: timer, event counter and pulse measurement.
// Behaviour
// - Count start bit high makes the counter count its selected source.
// - Count start bit low stops the counter.
// - Timer and event modes count down, reload on underflow, keep counting.
// - Programmed value n gives one underflow per n+1 source pulses.
// - Underflow sets the request flag; it holds until accepted or cleared.
// - Count register write while stopped in timer or event mode loads reload register and counter.
// - Write while counting loads only the reload register, used at next underflow.
// - Running read returns live count; read at reload instant returns all ones.
// - Read after a stopped write and before start returns the written value.
// - Event mode counts the external pin on falling, rising or both edges.
// - Event mode decrements once per valid external edge.
// - Measurement mode counts a prescaled clock divided by 2, 16, 64 or 512.
// - Measurement counts up; valid edge copies count to reload and clears.
// - Each measurement edge requests, except the first edge after start.
// - Measurement overflow requests and sets the overflow flag together.
// - Measurement read returns the captured reload value, not the live count.
// - Capture is undefined until the second valid edge after start.
// - Period mode times like edges; width mode times both levels.
// - Source selector bits 7:6 pick divide by 2, 16, 64 or 512.
// - Measurement selector bits 3:2: falling period, rising period, both width.
// - Overflow flag is read-only; mode write while running clears it next tick.
`timescale 1ns/1ps
`default_nettype none

module rtp_channel
  import rtp_pkg::*;
(
  input  wire logic         CLK,
  input  wire logic         RESET,
  input  wire logic         COUNT_START,
  input  wire logic         MODE_WR,
  input  wire rtp_mode_s    MODE_WDATA,
  input  wire rtp_cnt_acc_s COUNT_ACC,
  input  wire logic         IRQ_CLEAR,
  input  wire logic         IRQ_ACCEPT,
  input  wire logic         TIMER_EXT_INPUT,
  output var  logic [15:0]  COUNT_RDATA,
  output var  rtp_mode_s    MODE_RDATA,
  output var  logic         IRQ_REQUEST,
  output var  logic         OVERFLOW_FLAG,
  output var  logic         CAPTURE_VALID,
  output var  logic         RUNNING
);

  function automatic logic edge_valid(input logic [1:0] sel, input logic rise,
                                      input logic fall);
    case (sel)
      EDGE_FALL: edge_valid = fall;
      EDGE_RISE: edge_valid = rise;
      EDGE_BOTH: edge_valid = rise | fall;
      default:   edge_valid = 1'b0;
    endcase
  endfunction : edge_valid

  rtp_mode_s   mode_q;
  logic        run_q;
  logic [15:0] cnt_q;
  logic [15:0] reload_q;
  logic [15:0] rdata_q;
  logic        irq_q;
  logic        ovf_q;
  logic        ovf_clr_pend_q;
  logic [1:0]  edges_q;
  logic        capture_valid_q;
  logic        ext_s1_q;
  logic        ext_s2_q;
  logic        ext_s3_q;
  logic        pre_tick;
  logic        ext_rise;
  logic        ext_fall;
  logic        ext_valid;
  logic        is_meas;
  logic        count_tick;
  logic        underflow;
  logic        meas_edge;
  logic        ovf_evt;
  logic        sel_change;
  logic        start_evt;

  rtp_prescaler u_prescaler (
    .clk     (CLK),
    .reset   (RESET),
    .src_sel (mode_q.src_sel),
    .tick    (pre_tick)
  );

  // The pin is asynchronous; only the second stage and its delayed copy are read.
  // The stages reset to the idle high level, so no false edge follows reset.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_s3_q <= 1'b1;
    end else begin
      ext_s1_q <= TIMER_EXT_INPUT;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_rise  = ext_s2_q & ~ext_s3_q;
  assign ext_fall  = ~ext_s2_q & ext_s3_q;
  assign ext_valid = edge_valid(mode_q.edge_sel, ext_rise, ext_fall);
  assign is_meas   = (mode_q.op == OP_MEASURE);
  assign count_tick = (mode_q.op == OP_EVENT) ? ext_valid : pre_tick;
  assign underflow  = run_q && !is_meas && count_tick && (cnt_q == CNT_ZERO);
  assign meas_edge  = run_q && is_meas && ext_valid;
  assign ovf_evt    = run_q && is_meas && pre_tick && !meas_edge
                      && (cnt_q == CNT_ALL_ONES);
  assign sel_change = MODE_WR && run_q && is_meas
                      && (MODE_WDATA.edge_sel != mode_q.edge_sel);
  assign start_evt  = COUNT_START && !run_q;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      run_q <= 1'b0;
    end else begin
      run_q <= COUNT_START;
    end
  end

  // Operating mode is locked while running so the counter never sees a mixed mode.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mode_q <= rtp_mode_s'(MODE_RESET);
    end else if (MODE_WR) begin
      if (!run_q) begin
        mode_q.op <= MODE_WDATA.op;
      end
      mode_q.src_sel  <= MODE_WDATA.src_sel;
      mode_q.spare    <= MODE_WDATA.spare;
      mode_q.edge_sel <= MODE_WDATA.edge_sel;
    end
  end

  // Counter.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cnt_q <= CNT_ZERO;
    end else if (!run_q) begin
      if (COUNT_ACC.wr && !is_meas) begin
        cnt_q <= COUNT_ACC.wdata;
      end
    end else if (is_meas) begin
      if (meas_edge) begin
        cnt_q <= CNT_ZERO;
      end else if (pre_tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end else if (count_tick) begin
      if (cnt_q == CNT_ZERO) begin
        cnt_q <= reload_q;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // Reload register.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      reload_q <= CNT_ZERO;
    end else if (is_meas) begin
      if (meas_edge) begin
        reload_q <= cnt_q;
      end
    end else if (COUNT_ACC.wr) begin
      reload_q <= COUNT_ACC.wdata;
    end
  end

  // Read data is registered on the read strobe.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= CNT_ZERO;
    end else if (COUNT_ACC.rd) begin
      if (is_meas) begin
        rdata_q <= reload_q;
      end else if (underflow) begin
        rdata_q <= CNT_ALL_ONES;
      end else begin
        rdata_q <= cnt_q;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      edges_q <= 2'h0;
    end else if (start_evt) begin
      edges_q <= 2'h0;
    end else if (meas_edge && edges_q != EDGES_FOR_VALID) begin
      edges_q <= edges_q + 2'h1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      capture_valid_q <= 1'b0;
    end else if (start_evt) begin
      capture_valid_q <= 1'b0;
    end else if (meas_edge && edges_q == EDGES_FOR_VALID - 2'h1) begin
      capture_valid_q <= 1'b1;
    end
  end

  // A new request wins over a clear or an acceptance in the same cycle.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_q <= 1'b0;
    end else if (underflow || ovf_evt || sel_change || (meas_edge && edges_q != 2'h0)) begin
      irq_q <= 1'b1;
    end else if (IRQ_CLEAR || IRQ_ACCEPT) begin
      irq_q <= 1'b0;
    end
  end

  // The flag clears only on a source tick, so a late overflow still wins.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ovf_q          <= 1'b0;
      ovf_clr_pend_q <= 1'b0;
    end else begin
      if (ovf_evt) begin
        ovf_q <= 1'b1;
      end else if (ovf_clr_pend_q && pre_tick) begin
        ovf_q <= 1'b0;
      end
      if (MODE_WR && run_q) begin
        ovf_clr_pend_q <= 1'b1;
      end else if (pre_tick) begin
        ovf_clr_pend_q <= 1'b0;
      end
    end
  end

  assign COUNT_RDATA   = rdata_q;
  assign MODE_RDATA    = mode_q;
  assign IRQ_REQUEST   = irq_q;
  assign OVERFLOW_FLAG = ovf_q;
  assign CAPTURE_VALID = capture_valid_q;
  assign RUNNING       = run_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  property p_run_dec;
    run_q && !is_meas && count_tick && cnt_q != CNT_ZERO |=> cnt_q == $past(cnt_q) - 16'h0001;
  endproperty
  a_run_dec: assert property (p_run_dec) else $error("count did not decrement");

  property p_stop_hold;
    !run_q && !COUNT_ACC.wr |=> $stable(cnt_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

  property p_reload;
    underflow |=> cnt_q == $past(reload_q);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on underflow");

  property p_underflow_irq;
    underflow |=> irq_q;
  endproperty
  a_underflow_irq: assert property (p_underflow_irq) else $error("underflow lost request");

  property p_stop_write;
    !run_q && COUNT_ACC.wr && !is_meas
      |=> cnt_q == $past(COUNT_ACC.wdata) && reload_q == $past(COUNT_ACC.wdata);
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("stopped write not loaded");

  property p_run_write;
    run_q && COUNT_ACC.wr && !is_meas && !count_tick
      |=> $stable(cnt_q) && reload_q == $past(COUNT_ACC.wdata);
  endproperty
  a_run_write: assert property (p_run_write) else $error("running write misrouted");

  property p_reload_read;
    COUNT_ACC.rd && underflow |=> COUNT_RDATA == CNT_ALL_ONES;
  endproperty
  a_reload_read: assert property (p_reload_read) else $error("reload read not all ones");

  property p_capture;
    meas_edge |=> cnt_q == CNT_ZERO && reload_q == $past(cnt_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture failed");

  property p_first_edge;
    meas_edge && edges_q == 2'h0 && !irq_q && !sel_change ##1 start_evt == 1'b0 |-> !irq_q;
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("first edge raised request");

  property p_overflow;
    ovf_evt |=> irq_q && ovf_q;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_meas_read;
    COUNT_ACC.rd && is_meas |=> COUNT_RDATA == $past(reload_q);
  endproperty
  a_meas_read: assert property (p_meas_read) else $error("measurement read wrong");

  property p_meas_nowrite;
    is_meas && COUNT_ACC.wr && !meas_edge |=> $stable(reload_q);
  endproperty
  a_meas_nowrite: assert property (p_meas_nowrite) else $error("measurement write took");

  property p_valid_restart;
    start_evt |=> !CAPTURE_VALID;
  endproperty
  a_valid_restart: assert property (p_valid_restart) else $error("capture valid after start");

  property p_ovf_clear;
    ovf_clr_pend_q && pre_tick && !ovf_evt |=> !ovf_q;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  c_underflow: cover property (underflow ##1 irq_q);
  c_capture: cover property (meas_edge && edges_q == 2'h1);
  c_overflow: cover property (ovf_evt);
  c_event: cover property (run_q && mode_q.op == OP_EVENT && underflow);

endmodule : rtp_channel

`default_nettype wire

// ==== testbench/rtp_pulse_src.sv ====
// Behavioural source of the external pulse or event signal.
`timescale 1ns/1ps
`default_nettype none

module rtp_pulse_src (
  input  wire logic clk,
  output var  logic pin
);
  // The pin idles high, so the first change is always a falling edge.
  initial pin = 1'b1;

  // Levels change just after a falling clock edge, well clear of sampling.
  task automatic hold(input logic lvl, input int n);
    @(negedge clk);
    pin = lvl;
    repeat (n - 1) @(negedge clk);
  endtask : hold
endmodule : rtp_pulse_src
`default_nettype wire

// ==== testbench/reload_timer_pulse_measure_test.sv ====
// Self-checking bench for the reload timer channel.
`timescale 1ns/1ps
`default_nettype none

module reload_timer_pulse_measure_test;
  import rtp_pkg::*;
  logic         CLK, RESET, COUNT_START, MODE_WR, IRQ_CLEAR, IRQ_ACCEPT;
  logic         TIMER_EXT_INPUT, IRQ_REQUEST, OVERFLOW_FLAG, CAPTURE_VALID, RUNNING;
  rtp_mode_s    MODE_WDATA, MODE_RDATA;
  rtp_cnt_acc_s COUNT_ACC;
  logic [15:0]  COUNT_RDATA, v, w;
  logic [31:0]  lfsr;
  logic         auto_ack, lvl, prv;
  int           errors, samples_checked, cyc, irq_cnt, irq_t, irq_dt;
  int           n, base, ev, tn, tl, intv, ex;

  rtp_channel u_rtp_channel (.CLK(CLK), .RESET(RESET), .COUNT_START(COUNT_START),
    .MODE_WR(MODE_WR), .MODE_WDATA(MODE_WDATA), .COUNT_ACC(COUNT_ACC),
    .IRQ_CLEAR(IRQ_CLEAR), .IRQ_ACCEPT(IRQ_ACCEPT), .TIMER_EXT_INPUT(TIMER_EXT_INPUT),
    .COUNT_RDATA(COUNT_RDATA), .MODE_RDATA(MODE_RDATA), .IRQ_REQUEST(IRQ_REQUEST),
    .OVERFLOW_FLAG(OVERFLOW_FLAG), .CAPTURE_VALID(CAPTURE_VALID), .RUNNING(RUNNING));
  rtp_pulse_src u_rtp_pulse_src (.clk(CLK), .pin(TIMER_EXT_INPUT));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic finish_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Acknowledges each request so that every underflow, and each measurement edge after the first, is counted once.
  always @(negedge CLK) begin
    cyc++;
    IRQ_ACCEPT <= 1'b0;
    if (auto_ack && IRQ_REQUEST === 1'b1 && IRQ_ACCEPT === 1'b0) begin
      irq_cnt++;
      irq_dt = cyc - irq_t;
      irq_t = cyc;
      IRQ_ACCEPT <= 1'b1;
    end
    if (cyc > 60000) begin
      errors++;
      finish_test();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tk(input int k);
    repeat (k) @(negedge CLK);
  endtask : tk

  task automatic mode(input logic [1:0] src, input logic [1:0] es, input rtp_op_e op);
    MODE_WDATA = '{src, 2'h0, es, op};
    MODE_WR = 1'b1;
    tk(1);
    MODE_WR = 1'b0;
  endtask : mode

  task automatic cwr(input logic [15:0] d);
    COUNT_ACC = '{1'b1, 1'b0, d};
    tk(1);
    COUNT_ACC.wr = 1'b0;
  endtask : cwr

  task automatic crd(output logic [15:0] d);
    COUNT_ACC.rd = 1'b1;
    tk(1);
    COUNT_ACC.rd = 1'b0;
    tk(1);
    d = COUNT_RDATA;
  endtask : crd

  task automatic wirq(input int k);
    for (int i = 0; i < 12000 && irq_cnt < k; i++) tk(1);
  endtask : wirq

  initial begin
    RESET = 1'b1;
    COUNT_START = 1'b0;
    MODE_WR = 1'b0;
    MODE_WDATA = rtp_mode_s'(MODE_RESET);
    COUNT_ACC = '0;
    IRQ_CLEAR = 1'b0;
    auto_ack = 1'b1;
    {errors, samples_checked} = '0;
    lfsr = 32'hE924;
    tk(8);
    RESET = 1'b0;
    tk(2);
    chk({6'h0, IRQ_REQUEST, RUNNING, MODE_RDATA}, {8'h00, MODE_RESET});
    // Random reload values; the underflow spacing scales with each divider.
    for (int s = 0; s < 4; s++) begin
      lfsr = nxt(lfsr);
      n = lfsr[2:0] + 1;
      mode(s[1:0], EDGE_FALL, OP_TIMER);
      cwr(16'(n));
      crd(v);
      chk(v, 16'(n));
      COUNT_START = 1'b1;
      wirq(irq_cnt + 2);
      chk(16'(irq_dt), 16'((n + 1) * (s == 0 ? 2 : s == 1 ? 16 : s == 2 ? 64 : 512)));
      COUNT_START = 1'b0;
      tk(2);
    end
    mode(SRC_DIV2, EDGE_FALL, OP_TIMER);
    cwr(16'h0001);
    COUNT_START = 1'b1;
    wirq(irq_cnt + 1);
    cwr(16'h0003);
    mode(SRC_DIV2, EDGE_FALL, OP_EVENT);
    chk(16'(MODE_RDATA.op), 16'(OP_TIMER));
    wirq(irq_cnt + 2);
    chk(16'(irq_dt), 16'h0008);
    auto_ack = 1'b0;
    // Let a pending acceptance land before waiting for a fresh request.
    tk(1);
    for (int i = 0; i < 20 && IRQ_REQUEST !== 1'b1; i++) tk(1);
    COUNT_START = 1'b0;
    tk(20);
    chk(16'(IRQ_REQUEST), 16'h0001);
    IRQ_CLEAR = 1'b1;
    tk(1);
    IRQ_CLEAR = 1'b0;
    tk(1);
    chk(16'(IRQ_REQUEST), 16'h0000);
    auto_ack = 1'b1;
    crd(v);
    tk(20);
    crd(w);
    chk(w, v);
    // Event counting and measurement share one pin pattern and one edge model.
    for (int m = 0; m < 6; m++) begin
      COUNT_START = 1'b0;
      tk(1);
      mode(SRC_DIV2, 2'(m % 3), m < 3 ? OP_EVENT : OP_MEASURE);
      if (m < 3) cwr(16'h0001);
      base = irq_cnt;
      COUNT_START = 1'b1;
      tk(2);
      if (m < 3) crd(v);
      if (m < 3) chk(v, 16'h0001);
      if (m == 3) chk(16'(CAPTURE_VALID), 16'h0000);
      {ev, tn, tl, intv} = '0;
      prv = 1'b1;
      for (int k = 0; k < 4; k++) begin
        lvl = k[0];
        if ((!lvl && m % 3 != 1) || (lvl && m % 3 != 0)) begin
          if (ev > 0) intv = tn - tl;
          tl = tn;
          ev++;
        end
        u_rtp_pulse_src.hold(lvl, lvl ? 40 : 24);
        tn += lvl ? 40 : 24;
        prv = lvl;
      end
      tk(6);
      if (m < 3) begin
        chk(16'(irq_cnt - base), 16'(ev / 2));
      end else begin
        chk(16'(irq_cnt - base), 16'(ev - 1));
        chk(16'(CAPTURE_VALID), 16'h0001);
        crd(v);
        ex = intv / 2;
        chk(v, v === 16'(ex - 1) ? 16'(ex - 1) : 16'(ex));
      end
    end
    COUNT_START = 1'b0;
    tk(1);
    mode(SRC_DIV2, EDGE_FALL, OP_TIMER);
    cwr(16'h00A5);
    mode(SRC_DIV2, EDGE_RISE, OP_MEASURE);
    cwr(16'h1234);
    crd(v);
    chk(v, 16'h00A5);
    // The counter keeps a timer-mode value, so an overflow comes after sixteen ticks.
    mode(SRC_DIV2, EDGE_FALL, OP_TIMER);
    cwr(16'hFFF0);
    mode(SRC_DIV2, EDGE_FALL, OP_MEASURE);
    base = irq_cnt;
    COUNT_START = 1'b1;
    tk(48);
    chk(16'(OVERFLOW_FLAG), 16'h0001);
    chk(16'(irq_cnt - base), 16'h0001);
    mode(SRC_DIV2, EDGE_FALL, OP_MEASURE);
    tk(4);
    chk(16'(OVERFLOW_FLAG), 16'h0000);
    COUNT_START = 1'b0;
    tk(2);
    finish_test();
  end
endmodule : reload_timer_pulse_measure_test
`default_nettype wire
